// [bench/insn_env_model.sv]
// Program memory and register file model facing the decoder.
// Assumes fetches follow the fetch address and reads answer while the read pulse stands.
module insn_env_model (
  input wire logic i_sys_clk,
  input wire logic [12:0] i_pc,
  input wire logic [6:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [13:0] o_insn,
  output logic [7:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] prog [0:63];
  logic [7:0] regs [0:127];
  // Words past the loaded program read as zero, so the core idles safely.
  assign o_insn = (i_pc < 13'h0040) ? prog[i_pc[5:0]] : 14'h0000;
  // Read data stands only while the pulse does; otherwise it is inverted so that an
  // operand taken outside the pulse shows up as a wrong register value.
  assign o_rdata = i_rd ? regs[i_addr] : ~regs[i_addr];
  // Writes land on the edge that samples the write pulse.
  always @(posedge i_sys_clk) begin
    if (i_wr) regs[i_addr] <= i_wdata;
  end
endmodule

// [bench/instruction_operand_decode_sva.sv]
// Timing checker for the decoder's reads, writes, fetches and flush cycles.
// Assumes it is bound to the decoder top: one clock, synchronous reset.
module instruction_operand_decode_chk #(
  parameter PC_W = 13
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire [PC_W-1:0] o_pc,
  input wire [6:0] o_rf_addr,
  input wire o_rf_rd,
  input wire o_rf_wr,
  input wire [7:0] o_acc,
  input wire o_flush
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Each instruction cycle owns four clocks, so pulses and fetches cannot crowd.
  property p_rd_gap; o_rf_rd |=> !o_rf_rd [*3]; endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("read pulse repeated");
  property p_wr_gap; o_rf_wr |=> !o_rf_wr [*3]; endproperty
  a_wr_gap: assert property (p_wr_gap) else $error("write pulse repeated");
  property p_pc_step; !$stable(o_pc) |=> $stable(o_pc) [*3]; endproperty
  a_pc_step: assert property (p_pc_step) else $error("fetch address moved early");
  // A write-back always follows a read of the same location three clocks before.
  property p_rmw; o_rf_wr |-> $past(o_rf_rd, 3); endproperty
  a_rmw: assert property (p_rmw) else $error("write without prior read");
  property p_wr_addr; o_rf_wr |-> o_rf_addr == $past(o_rf_addr, 3); endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("write address differs");
  property p_acc_keep; o_rf_wr |-> $stable(o_acc); endproperty
  a_acc_keep: assert property (p_acc_keep) else $error("acc moved on file write");
  // The discarded cycle lasts exactly one instruction cycle and issues no register read.
  property p_flush_len; $rose(o_flush) |-> o_flush [*4] ##1 !o_flush; endproperty
  a_flush_len: assert property (p_flush_len) else $error("flush length wrong");
  property p_flush_quiet; o_flush |-> !o_rf_rd; endproperty
  a_flush_quiet: assert property (p_flush_quiet) else $error("read in flush");
  property p_rst_clear;
    disable iff (1'b0) i_rst |=> o_acc == 8'h00 && o_pc == 0 && !o_flush && !o_rf_wr;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("reset left state");
  c_wr: cover property (o_rf_wr);
  c_flush: cover property ($rose(o_flush));
  c_rd_only: cover property (o_rf_rd ##3 !o_rf_wr);
endmodule
bind instruction_operand_decode instruction_operand_decode_chk #(.PC_W(PC_W)) chk_i (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .o_pc(o_pc), .o_rf_addr(o_rf_addr),
  .o_rf_rd(o_rf_rd), .o_rf_wr(o_rf_wr), .o_acc(o_acc), .o_flush(o_flush));

// [bench/test_instruction_operand_decode.sv]
// Self-checking bench: one seeded random program runs against the memory and register model.
// Assumes the decoder's hand-over timing and the model in insn_env_model.
module test_instruction_operand_decode;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 40;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [13:0] insn;
  logic [7:0] rdata, wdata, acc;
  logic [12:0] pc;
  logic [6:0] addr;
  logic [2:0] status;
  logic rd, wr, flush;
  logic [7:0] exp_rf [0:127];
  logic [7:0] exp_acc = 8'h00;
  logic exp_z = 1'b0;
  int flush_seen = 0;
  int failures = 0;
  int checks_done = 0;
  int rd_seen = 0;
  int rd_exp = 0;
  int k;
  instruction_operand_decode instruction_operand_decode_i (.i_sys_clk(i_sys_clk),
    .i_rst(i_rst), .i_insn(insn), .i_rf_rdata(rdata), .o_pc(pc), .o_rf_addr(addr),
    .o_rf_rd(rd), .o_rf_wr(wr), .o_rf_wdata(wdata), .o_acc(acc), .o_status(status),
    .o_flush(flush));
  insn_env_model insn_env_model_i (.i_sys_clk(i_sys_clk), .i_pc(pc), .i_addr(addr),
    .i_rd(rd), .i_wr(wr), .i_wdata(wdata), .o_insn(insn), .o_rdata(rdata));
  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // Count every register read the decoder issues and every discarded clock.
  always @(posedge i_sys_clk) begin
    if (rd === 1'b1) rd_seen++;
    if (flush === 1'b1) flush_seen++;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (failures == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Work out the register file and accumulator after one word.
  function automatic void predict(input logic [13:0] w);
    logic [7:0] v;
    v = exp_rf[w[6:0]];
    if (w[13:8] == 6'h08) begin
      rd_exp++;
      if (w[7]) exp_rf[w[6:0]] = v;
      else exp_acc = v;
      exp_z = (v == 8'h00);
    end else if (w[13:11] == 3'b010) begin
      rd_exp++;
      v[w[9:7]] = w[10];
      exp_rf[w[6:0]] = v;
    end else if (w[13:7] == 7'h02) begin
      exp_acc = 8'h00;
      exp_z = 1'b1;
    end
  endfunction
  // Load a random program with corner words, predict it, run it, compare.
  initial begin
    logic [13:0] w;
    int pcx;
    k = $urandom(92433);
    for (k = 0; k < 64; k++) insn_env_model_i.prog[k] = 14'h0000;
    for (k = 0; k < 128; k++) begin
      exp_rf[k] = 8'($urandom);
      insn_env_model_i.regs[k] = exp_rf[k];
    end
    for (k = 0; k < N; k++) begin
      w = {3'b010, 1'($urandom), 3'($urandom), 7'd5 + 7'($urandom_range(122))};
      if (k % 2 == 0) w[13:7] = {6'h08, 1'($urandom)};
      insn_env_model_i.prog[k] = w;
    end
    insn_env_model_i.prog[0] = 14'h087F;
    insn_env_model_i.prog[5] = 14'h017F;
    insn_env_model_i.prog[N-3] = 14'(14'h2800 + N - 1);
    insn_env_model_i.prog[N-2] = 14'h17FF;
    pcx = 0;
    while (pcx < N) begin
      w = insn_env_model_i.prog[pcx];
      predict(w);
      pcx = (w[13:11] == 3'b101) ? int'(w[10:0]) : pcx + 1;
    end
    repeat (12) @(posedge i_sys_clk);
    #1 i_rst = 1'b0;
    repeat (4 * N + 40) @(posedge i_sys_clk);
    #1;
    check("acc", acc, exp_acc);
    check("reads", 8'(rd_seen), 8'(rd_exp));
    check("status", {5'h00, status}, {5'h00, exp_z, 2'b00});
    check("flush cycles", 8'(flush_seen), 8'h04);
    for (k = 0; k < 128; k++) check("reg", insn_env_model_i.regs[k], exp_rf[k]);
    complete_run();
  end
  // Cut a hang short well past the program's length.
  initial begin
    repeat (8 * N + 200) @(posedge i_sys_clk);
    failures++;
    complete_run();
  end
endmodule

// [rtl/insn_decode_consts.vh]
// Constants for the instruction decode and sequencing block.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef INSN_DECODE_CONSTS_VH
`define INSN_DECODE_CONSTS_VH
`define IW_WIDTH 14
`define FADDR_WIDTH 7
`define DATA_WIDTH 8
`define PC_WIDTH 13
`define LIT_SHORT_WIDTH 8
`define LIT_LONG_WIDTH 11
`define PHASES_PER_CYCLE 4
`define DEST_BIT 7
`define BIT_IDX_LSB 7
`define STATUS_ADDR 7'h03
`define PCL_ADDR 7'h02
`define STATUS_Z_BIT 2
`define STATUS_C_BIT 0
`define NOP_WORD 14'h0000
`define RESET_VECTOR 13'h0000
`endif

// [rtl/instruction_operand_decode.v]
// Instruction decoder and sequencer for an 8-bit core with 14-bit instruction words.
// Assumes program memory answers a fetch within the same cycle and the register file
// answers a read one oscillator period after the address is presented.
`include "insn_decode_consts.vh"

module instruction_operand_decode #(
  parameter PC_W = `PC_WIDTH
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire [`IW_WIDTH-1:0] i_insn,
  input wire [`DATA_WIDTH-1:0] i_rf_rdata,
  output reg [PC_W-1:0] o_pc,
  output reg [`FADDR_WIDTH-1:0] o_rf_addr,
  output reg o_rf_rd,
  output reg o_rf_wr,
  output reg [`DATA_WIDTH-1:0] o_rf_wdata,
  output reg [`DATA_WIDTH-1:0] o_acc,
  output reg [2:0] o_status,
  output reg o_flush
);
  wire [3:0] phase;
  wire cycle_end;
  reg [`IW_WIDTH-1:0] ir_reg;
  reg flush_reg;
  reg [`DATA_WIDTH-1:0] opnd_reg;
  reg [PC_W-1:0] stack_reg [0:7];
  reg [2:0] sp_reg;
  reg [`DATA_WIDTH-1:0] res;
  reg wr_f;
  reg wr_w;
  reg set_z;
  reg set_c;
  reg c_out;
  reg skip;
  reg jump;
  reg call;
  reg ret;
  reg [PC_W-1:0] target;
  reg [`DATA_WIDTH-1:0] sum;
  reg [`DATA_WIDTH:0] wide;
  // Field views of the held word; bits outside a format's fields are never read.
  wire [1:0] fmt = ir_reg[13:12];
  wire [3:0] op_byte = ir_reg[11:8];
  wire [1:0] op_bit = ir_reg[11:10];
  wire [3:0] op_lit = ir_reg[11:8];
  wire dest = ir_reg[`DEST_BIT];
  wire [`FADDR_WIDTH-1:0] faddr = ir_reg[`FADDR_WIDTH-1:0];
  wire [2:0] bidx = ir_reg[`BIT_IDX_LSB+2:`BIT_IDX_LSB];
  wire [`LIT_SHORT_WIDTH-1:0] k8 = ir_reg[`LIT_SHORT_WIDTH-1:0];
  wire [`LIT_LONG_WIDTH-1:0] k11 = ir_reg[`LIT_LONG_WIDTH-1:0];
  // Byte words with opcode 0 or 1 and a clear destination bit (no-op, return, clear of the
  // accumulator) name no register, so they must not disturb one with a stray read.
  wire names_reg = (op_byte[3:1] != 3'b000) || dest;

  phase_gen #(.PHASES(`PHASES_PER_CYCLE)) u_phase (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .o_phase(phase),
    .o_cycle_end(cycle_end)
  );

  // One-hot mask with a single bit set, used by the bit set and clear operations.
  function [7:0] bit_mask;
    input [2:0] idx;
    begin
      bit_mask = 8'h01 << idx;
    end
  endfunction

  // Execute decode; only the addressed bit is changed by bit instructions.
  always @* begin
    res = opnd_reg;
    wr_f = 1'b0;
    wr_w = 1'b0;
    set_z = 1'b0;
    set_c = 1'b0;
    c_out = 1'b0;
    skip = 1'b0;
    jump = 1'b0;
    call = 1'b0;
    ret = 1'b0;
    target = o_pc;
    sum = 8'h00;
    wide = 9'h000;
    case (fmt)
      2'b00: begin
        case (op_byte)
          4'h0: begin
            if (dest) begin
              wr_f = 1'b1; // accumulator to register
              res = o_acc;
            end else if (ir_reg[3:0] == 4'h8) begin
              ret = 1'b1;
            end
          end
          4'h1: begin
            res = 8'h00;
            set_z = 1'b1;
            wr_f = dest;
            wr_w = ~dest;
          end
          4'h2: begin
            wide = {1'b0, opnd_reg} + {1'b0, ~o_acc} + 9'h001;
            res = wide[7:0];
            set_z = 1'b1;
            set_c = 1'b1;
            c_out = wide[8];
          end
          4'h3: res = opnd_reg - 8'h01;
          4'h4: res = opnd_reg | o_acc;
          4'h5: res = opnd_reg & o_acc;
          4'h6: res = opnd_reg ^ o_acc;
          4'h7: begin
            wide = {1'b0, opnd_reg} + {1'b0, o_acc};
            res = wide[7:0];
            set_c = 1'b1;
            c_out = wide[8];
          end
          4'h8: res = opnd_reg;
          4'h9: res = ~opnd_reg;
          4'hA: res = opnd_reg + 8'h01;
          4'hB: begin
            res = opnd_reg - 8'h01;
            skip = (res == 8'h00);
          end
          4'hC: begin
            res = {o_status[`STATUS_C_BIT], opnd_reg[7:1]};
            set_c = 1'b1;
            c_out = opnd_reg[0];
          end
          4'hD: begin
            res = {opnd_reg[6:0], o_status[`STATUS_C_BIT]};
            set_c = 1'b1;
            c_out = opnd_reg[7];
          end
          4'hE: res = {opnd_reg[3:0], opnd_reg[7:4]};
          4'hF: begin
            res = opnd_reg + 8'h01;
            skip = (res == 8'h00);
          end
          default: res = opnd_reg;
        endcase
        // Destination select for all byte operations except the move and clear.
        if (op_byte != 4'h0 && op_byte != 4'h1) begin
          wr_f = dest;
          wr_w = ~dest;
          set_z = set_z | (op_byte != 4'hB && op_byte != 4'hF && op_byte != 4'hC
                           && op_byte != 4'hD && op_byte != 4'hE);
        end
      end
      2'b01: begin
        case (op_bit)
          2'b00: begin
            res = opnd_reg & ~bit_mask(bidx);
            wr_f = 1'b1;
          end
          2'b01: begin
            res = opnd_reg | bit_mask(bidx);
            wr_f = 1'b1;
          end
          2'b10: skip = ~opnd_reg[bidx];
          2'b11: skip = opnd_reg[bidx];
          default: skip = 1'b0;
        endcase
      end
      2'b10: begin
        jump = 1'b1;
        call = ~ir_reg[11];
        target = {{(PC_W-`LIT_LONG_WIDTH){1'b0}}, k11};
      end
      default: begin
        wr_w = 1'b1;
        case (op_lit[3:1])
          3'b111: begin
            wide = {1'b0, k8} + {1'b0, o_acc};
            sum = wide[7:0];
            set_c = 1'b1;
            c_out = wide[8];
          end
          3'b110: begin
            wide = {1'b0, k8} + {1'b0, ~o_acc} + 9'h001;
            sum = wide[7:0];
            set_c = 1'b1;
            c_out = wide[8];
          end
          3'b100: sum = k8 | o_acc;
          3'b101: sum = (op_lit[0]) ? (k8 ^ o_acc) : (k8 & o_acc);
          3'b010: begin
            sum = k8; // return with literal
            ret = 1'b1;
          end
          default: sum = k8;
        endcase
        res = sum;
        set_z = (op_lit[3:2] != 2'b00);
      end
    endcase
  end

  // Sequencer: fetch at cycle end, operand read in phase two, write-back in phase four.
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_pc <= `RESET_VECTOR;
      ir_reg <= `NOP_WORD;
      flush_reg <= 1'b0;
      opnd_reg <= 8'h00;
      sp_reg <= 3'h0;
      o_rf_addr <= 7'h00;
      o_rf_rd <= 1'b0;
      o_rf_wr <= 1'b0;
      o_rf_wdata <= 8'h00;
      o_acc <= 8'h00;
      o_status <= 3'h0;
      o_flush <= 1'b0;
    end else begin
      o_rf_rd <= 1'b0;
      o_rf_wr <= 1'b0;
      if (phase[0] && !flush_reg) begin
        o_rf_addr <= faddr;
        o_rf_rd <= (fmt == 2'b01) || ((fmt == 2'b00) && names_reg);
      end
      if (phase[1]) begin
        opnd_reg <= i_rf_rdata;
      end
      if (phase[3] && !flush_reg) begin
        o_rf_wr <= wr_f;
        o_rf_wdata <= res;
        if (wr_w) begin
          o_acc <= res;
        end
        if (set_z) begin
          o_status[`STATUS_Z_BIT] <= (res == 8'h00);
        end
        if (set_c) begin
          o_status[`STATUS_C_BIT] <= c_out;
        end
      end
      if (cycle_end) begin
        // A flushed cycle runs as a no-operation, then normal fetch resumes.
        if (!flush_reg && (skip || jump || ret)) begin
          flush_reg <= 1'b1;
          o_flush <= 1'b1;
          ir_reg <= `NOP_WORD;
          if (call) begin
            stack_reg[sp_reg] <= o_pc;
            sp_reg <= sp_reg + 3'h1;
          end
          if (ret) begin
            o_pc <= stack_reg[sp_reg - 3'h1];
            sp_reg <= sp_reg - 3'h1;
          end else if (jump) begin
            o_pc <= target;
          end else begin
            o_pc <= o_pc + {{(PC_W-1){1'b0}}, 1'b1};
          end
        end else begin
          flush_reg <= 1'b0;
          o_flush <= 1'b0;
          ir_reg <= i_insn;
          o_pc <= o_pc + {{(PC_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// [rtl/phase_gen.v]
// Four-phase generator that splits each instruction cycle into oscillator periods.
// Assumes one system clock period stands for one oscillator period.
`include "insn_decode_consts.vh"

module phase_gen #(
  parameter PHASES = `PHASES_PER_CYCLE
) (
  input wire i_sys_clk,
  input wire i_rst,
  output reg [3:0] o_phase,
  output reg o_cycle_end
);
  // Rotating one-hot phase; the last phase marks the end of a cycle.
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_phase <= 4'h1;
      o_cycle_end <= 1'b0;
    end else begin
      o_phase <= {o_phase[2:0], o_phase[3]};
      o_cycle_end <= o_phase[2];
    end
  end
endmodule
